// file: rtl/ltc_pkg.sv
package ltc_pkg;
  localparam int SEG_W = 48;
  localparam int TAG_W = 32;
  localparam int RNG_W = 16;
  localparam int NTRIG = 8;
  localparam int LVL_W = 3;
  localparam int PTR_W = 8;
  localparam int AW    = 8;
  localparam logic [PTR_W-1:0] CAP      = 8'hff;
  localparam logic [PTR_W-1:0] LAST_PTR = 8'hfe;
  localparam logic [5:0]       SEG_W6   = 6'h30;
  // register offsets
  localparam logic [AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AW-1:0] REG_PRE    = 8'h08;
  localparam logic [AW-1:0] REG_RANGE  = 8'h0c;
  localparam logic [AW-1:0] REG_RDIDX  = 8'h10;
  localparam logic [AW-1:0] REG_RDA0   = 8'h14;
  localparam logic [AW-1:0] REG_RDA1   = 8'h18;
  localparam logic [AW-1:0] REG_RDB0   = 8'h1c;
  localparam logic [AW-1:0] REG_RDB1   = 8'h20;
  localparam logic [AW-1:0] REG_RDTAG  = 8'h24;
  localparam logic [AW-1:0] TRIG_BASE  = 8'h40;
  // trigger sub-registers, addr[3:2]
  localparam logic [1:0] TS_VLO = 2'h0;
  localparam logic [1:0] TS_VHI = 2'h1;
  localparam logic [1:0] TS_MLO = 2'h2;
  localparam logic [1:0] TS_MHI = 2'h3;
  localparam int TS_LVL = 16;
  localparam int TS_BRK = 24;
  // control fields
  localparam int CTL_ARM   = 0;
  localparam int CTL_STOP  = 1;
  localparam int CTL_MODE  = 2;
  localparam int CTL_EXCL  = 4;
  localparam int CTL_EXP   = 5;
  localparam int CTL_SPLIT = 8;
  localparam int CTL_DEPTH = 16;
  // status fields
  localparam int STS_BUSY = 0;
  localparam int STS_POST = 1;
  localparam int STS_DONE = 2;
  localparam int STS_LVL  = 8;
  localparam int STS_FILL = 16;
  localparam int STS_PCNT = 24;
  localparam int RNG_HI   = 16;
  typedef enum logic [1:0] {
    MODE_START = 2'b00,
    MODE_END   = 2'b01,
    MODE_PRE   = 2'b10
  } ltc_mode_e;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_POST  = 2'b10,
    ST_DONE  = 2'b11
  } ltc_state_e;
endpackage

// file: rtl/ltc_trigger.sv
`timescale 1ns/1ps
module ltc_trigger #(
  parameter int W  = 48,
  parameter int LW = 3
) (
  input  wire logic [W-1:0]  sample,
  input  wire logic [W-1:0]  value,
  input  wire logic [W-1:0]  mask,
  input  wire logic [LW-1:0] level,
  input  wire logic [LW-1:0] curLevel,
  output logic               match,
  output logic               levelHit
);
  // mask bit set means the bit is compared
  assign match    = ((sample ^ value) & mask) == '0;
  assign levelHit = match && (level == curLevel);
endmodule

// file: rtl/ltc_capture.sv
`timescale 1ns/1ps
module ltc_capture (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic [ltc_pkg::AW-1:0] regAddr,
  input  wire logic [31:0]            regWrData,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [31:0]            regRdData,
  input  wire logic                   probeClk,
  input  wire logic [95:0]            probeData,
  output logic                        syncOut,
  output logic                        brkReq
);
  localparam int SW = ltc_pkg::SEG_W;
  localparam int NT = ltc_pkg::NTRIG;
  localparam int LW = ltc_pkg::LVL_W;
  localparam int PW = ltc_pkg::PTR_W;

  logic [2:0]              clkSync;
  logic [95:0]             d1;
  logic [95:0]             d2;
  logic [95:0]             d3;
  logic                    clkLvl;
  logic                    clkPrev;
  ltc_pkg::ltc_mode_e      mode;
  ltc_pkg::ltc_state_e     state;
  ltc_pkg::ltc_state_e     next_state;
  logic                    excl;
  logic                    expEn;
  logic [5:0]              split;
  logic [LW-1:0]           depth;
  logic [PW-1:0]           preCnt;
  logic [15:0]             rngLo;
  logic [15:0]             rngHi;
  logic [PW-1:0]           rdIdx;
  logic [SW-1:0]           trigVal [NT];
  logic [SW-1:0]           trigMask [NT];
  logic [LW-1:0]           trigLvl [NT];
  logic [NT-1:0]           trigBrk;
  logic [LW-1:0]           curLevel;
  logic [ltc_pkg::TAG_W-1:0] tagCnt;
  logic [PW-1:0]           wrPtr;
  logic [PW-1:0]           fill;
  logic [PW-1:0]           postCnt;
  logic [SW-1:0]           memA [255];
  logic [SW-1:0]           memB [255];
  logic [ltc_pkg::TAG_W-1:0] memT [255];
  logic [NT-1:0]           match;
  logic [NT-1:0]           lvlHit;
  logic [31:0]             rdMux;

  // probe pins: three stages, level changes when 2nd and 3rd agree
  always_ff @(posedge sys_clk) begin
    clkSync <= {clkSync[1:0], probeClk};
    d1 <= probeData;
    d2 <= d1;
    d3 <= d2;
  end

  // sampling tied to filtered probe clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      clkLvl  <= 1'b0;
      clkPrev <= 1'b0;
    end else begin
      if (clkSync[1] == clkSync[2]) begin
        clkLvl <= clkSync[2];
      end
      clkPrev <= clkLvl;
    end
  end
  wire sampEv = clkLvl && !clkPrev;

  // register decode
  wire wrCtrl  = regWr && (regAddr == ltc_pkg::REG_CTRL);
  wire arm     = wrCtrl && regWrData[ltc_pkg::CTL_ARM];
  wire stopCmd = wrCtrl && regWrData[ltc_pkg::CTL_STOP];
  // triggers k at base + 16k, eight slots of four words
  wire [ltc_pkg::AW-1:0] tOff = regAddr - ltc_pkg::TRIG_BASE;
  wire wrTrig  = regWr && !tOff[ltc_pkg::AW-1];
  wire [2:0] tIdx = tOff[6:4];
  wire [1:0] tSub = tOff[3:2];
  wire busy    = (state == ltc_pkg::ST_ARMED) || (state == ltc_pkg::ST_POST);

  // mode and configuration held until rewritten
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode  <= ltc_pkg::MODE_START;
      excl  <= 1'b0;
      expEn <= 1'b0;
      split <= '0;
      depth <= '0;
    end else if (wrCtrl) begin
      mode  <= ltc_pkg::ltc_mode_e'(regWrData[ltc_pkg::CTL_MODE +: 2]);
      excl  <= regWrData[ltc_pkg::CTL_EXCL];
      expEn <= regWrData[ltc_pkg::CTL_EXP];
      split <= regWrData[ltc_pkg::CTL_SPLIT +: 6];
      depth <= regWrData[ltc_pkg::CTL_DEPTH +: LW];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      preCnt <= '0;
      rngLo  <= '0;
      rngHi  <= '1;
      rdIdx  <= '0;
    end else if (regWr) begin
      if (regAddr == ltc_pkg::REG_PRE) begin
        preCnt <= regWrData[PW-1:0];
      end
      if (regAddr == ltc_pkg::REG_RANGE) begin
        rngLo <= regWrData[15:0];
        rngHi <= regWrData[ltc_pkg::RNG_HI +: 16];
      end
      if (regAddr == ltc_pkg::REG_RDIDX) begin
        rdIdx <= regWrData[PW-1:0];
      end
    end
  end

  // each trigger gets a level and optional break
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int k = 0; k < NT; k++) begin
        trigVal[k]  <= '0;
        trigMask[k] <= '0;
        trigLvl[k]  <= '0;
      end
      trigBrk <= '0;
    end else if (wrTrig) begin
      case (tSub)
        ltc_pkg::TS_VLO: trigVal[tIdx][31:0]  <= regWrData;
        ltc_pkg::TS_VHI: begin
          trigVal[tIdx][SW-1:32] <= regWrData[15:0];
          trigLvl[tIdx] <= regWrData[ltc_pkg::TS_LVL +: LW];
          trigBrk[tIdx] <= regWrData[ltc_pkg::TS_BRK];
        end
        ltc_pkg::TS_MLO: trigMask[tIdx][31:0] <= regWrData;
        default: trigMask[tIdx][SW-1:32] <= regWrData[15:0];
      endcase
    end
  end

  // top split bits replaced by the edge count
  wire [SW-1:0] tMask  = ~({SW{1'b1}} >> split);
  wire [5:0]    cntSh  = ltc_pkg::SEG_W6 - split;
  wire [SW-1:0] cntExt = {{(SW-ltc_pkg::TAG_W){1'b0}}, tagCnt} << cntSh;
  wire [SW-1:0] segA   = (d3[SW-1:0] & ~tMask) | (cntExt & tMask);
  wire [SW-1:0] segB   = d3[95:SW];

  for (genvar k = 0; k < NT; k++) begin : g_trig
    ltc_trigger #(.W(SW), .LW(LW)) u_trig (
      .sample   (segA),
      .value    (trigVal[k]),
      .mask     (trigMask[k]),
      .level    (trigLvl[k]),
      .curLevel (curLevel),
      .match    (match[k]),
      .levelHit (lvlHit[k])
    );
  end

  // any trigger on the current level satisfies it
  wire seqHit   = |lvlHit;
  // depth field holds levels minus one
  wire lastLvl  = curLevel == depth;
  wire complete = sampEv && (state == ltc_pkg::ST_ARMED) && seqHit && lastLvl;

  // low 16 bits of each segment in use
  wire inA  = (segA[15:0] >= rngLo) && (segA[15:0] <= rngHi);
  wire inB  = (segB[15:0] >= rngLo) && (segB[15:0] <= rngHi);
  wire qual = (inA ^ excl) && (!expEn || (inB ^ excl));

  wire postPhase = (state == ltc_pkg::ST_POST) || complete;
  wire preStore  = (state == ltc_pkg::ST_ARMED) &&
                   (mode == ltc_pkg::MODE_END || mode == ltc_pkg::MODE_PRE);
  wire store = sampEv && qual && (preStore || postPhase);

  wire [PW-1:0] preLeft = ltc_pkg::CAP - preCnt;
  wire [PW-1:0] target  =
    (mode == ltc_pkg::MODE_END) ? 8'h01 :
    (mode == ltc_pkg::MODE_PRE) ? ((preLeft == '0) ? 8'h01 : preLeft) :
    ltc_pkg::CAP;
  wire finish = store && postPhase &&
                ({1'b0, postCnt} + 9'h001 >= {1'b0, target});

  always_comb begin
    next_state = state;
    if (arm) begin
      next_state = ltc_pkg::ST_ARMED;
    end else if (stopCmd && busy) begin
      next_state = ltc_pkg::ST_DONE;
    end else begin
      case (state)
        ltc_pkg::ST_ARMED: begin
          if (finish) begin
            next_state = ltc_pkg::ST_DONE;
          end else if (complete) begin
            next_state = ltc_pkg::ST_POST;
          end
        end
        ltc_pkg::ST_POST: begin
          // stop once the target is reached
          if (finish) begin
            next_state = ltc_pkg::ST_DONE;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ltc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  wire advLvl = sampEv && (state == ltc_pkg::ST_ARMED) && seqHit && !lastLvl;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || arm) begin
      curLevel <= '0;
    end else if (advLvl) begin
      curLevel <= curLevel + 3'h1;
    end
  end

  // tag counts every probe clock while running
  always_ff @(posedge sys_clk) begin
    if (sys_rst || arm) begin
      tagCnt <= '0;
    end else if (busy && sampEv) begin
      tagCnt <= tagCnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || arm) begin
      wrPtr   <= '0;
      fill    <= '0;
      postCnt <= '0;
    end else if (store) begin
      wrPtr <= (wrPtr == ltc_pkg::LAST_PTR) ? '0 : wrPtr + 8'h01;
      if (fill != ltc_pkg::CAP) begin
        fill <= fill + 8'h01;
      end
      if (postPhase) begin
        postCnt <= postCnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (store) begin
      memA[wrPtr] <= segA;
      memB[wrPtr] <= expEn ? segB : '0;
      memT[wrPtr] <= tagCnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      syncOut <= 1'b0;
      brkReq  <= 1'b0;
    end else begin
      syncOut <= complete;
      // break on any enabled trigger match
      brkReq  <= sampEv && busy && |(match & trigBrk);
    end
  end

  // readout ordered oldest first
  wire [PW-1:0] oldest = (fill == ltc_pkg::CAP) ? wrPtr : '0;
  wire [8:0]    rawIdx = {1'b0, oldest} + {1'b0, rdIdx};
  wire [8:0]    wrapIx = (rawIdx >= {1'b0, ltc_pkg::CAP}) ?
                         rawIdx - {1'b0, ltc_pkg::CAP} : rawIdx;
  wire [PW-1:0] physIx = wrapIx[PW-1:0];
  wire [31:0]   status = {postCnt, fill, 5'h00, curLevel, 5'h00,
                          state == ltc_pkg::ST_DONE,
                          state == ltc_pkg::ST_POST, busy};
  wire [SW-1:0] rdA = memA[physIx];
  wire [SW-1:0] rdB = memB[physIx];

  // buffer words read as zero while capture runs
  always_comb begin
    rdMux = '0;
    case (regAddr)
      ltc_pkg::REG_CTRL: begin
        rdMux[ltc_pkg::CTL_MODE +: 2]   = mode;
        rdMux[ltc_pkg::CTL_EXCL]        = excl;
        rdMux[ltc_pkg::CTL_EXP]         = expEn;
        rdMux[ltc_pkg::CTL_SPLIT +: 6]  = split;
        rdMux[ltc_pkg::CTL_DEPTH +: LW] = depth;
      end
      ltc_pkg::REG_STATUS: rdMux = status;
      ltc_pkg::REG_PRE:    rdMux = {24'h0, preCnt};
      ltc_pkg::REG_RANGE:  rdMux = {rngHi, rngLo};
      ltc_pkg::REG_RDIDX:  rdMux = {24'h0, rdIdx};
      ltc_pkg::REG_RDA0:   rdMux = busy ? '0 : rdA[31:0];
      ltc_pkg::REG_RDA1:   rdMux = busy ? '0 : {16'h0, rdA[SW-1:32]};
      ltc_pkg::REG_RDB0:   rdMux = busy ? '0 : rdB[31:0];
      ltc_pkg::REG_RDB1:   rdMux = busy ? '0 : {16'h0, rdB[SW-1:32]};
      ltc_pkg::REG_RDTAG:  rdMux = busy ? '0 : memT[physIx];
      default:             rdMux = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRd ? rdMux : '0;
    end
  end

  sync_pulse_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    complete |=> syncOut ##1 !syncOut)
    else $error("sync pulse missing or too long");

  brk_req_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (sampEv && busy && |(match & trigBrk)) |=> brkReq)
    else $error("breakpoint request not raised");

  fill_cap_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    fill <= ltc_pkg::CAP && wrPtr <= ltc_pkg::LAST_PTR)
    else $error("buffer bounds exceeded");

  wrap_ptr_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (store && !arm && wrPtr == ltc_pkg::LAST_PTR) |=> wrPtr == '0)
    else $error("write pointer did not wrap");

  start_nopre_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (state == ltc_pkg::ST_ARMED && mode == ltc_pkg::MODE_START
     && !complete) |-> !store)
    else $error("start mode stored before completion");

  qual_store_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (sampEv && busy && !qual && !arm) |=> $stable(fill) && $stable(postCnt))
    else $error("unqualified sample counted");

  end_stop_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (complete && qual && mode == ltc_pkg::MODE_END && !arm && !stopCmd)
    |=> state == ltc_pkg::ST_DONE)
    else $error("end mode did not stop on trigger");

  post_bound_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    state == ltc_pkg::ST_POST |-> postCnt < target)
    else $error("post count overran target");

  read_block_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (regRd && busy && regAddr == ltc_pkg::REG_RDTAG) |=> regRdData == '0)
    else $error("buffer visible while running");

  level_seq_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (state == ltc_pkg::ST_ARMED && !arm && sampEv && seqHit && !lastLvl)
    |=> curLevel == $past(curLevel) + 3'h1)
    else $error("level did not advance");

  tag_count_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (busy && sampEv && !arm) |=> tagCnt == $past(tagCnt) + 32'h1)
    else $error("tag counter did not step");
endmodule

// file: tb/ltc_probe_model.sv
`timescale 1ns/1ps
module ltc_probe_model (
  input  wire logic        sys_clk,
  output logic             probeClk,
  output logic [95:0]      probeData
);
  initial begin
    probeClk  = 1'b0;
    probeData = '0;
  end

  // one edge per ten system clocks
  task automatic send(input logic [95:0] w);
    @(posedge sys_clk);
    probeData <= w;
    probeClk  <= 1'b1;
    repeat (5) @(posedge sys_clk);
    probeClk  <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // data no longer held: show the inverse
    probeData <= ~w;
  endtask
endmodule

// file: tb/ltc_capture_tb.sv
`timescale 1ns/1ps
module ltc_capture_tb;
  localparam logic [47:0] M  = 48'hffff_ffff_ffff;
  localparam logic [47:0] TA = 48'h0000_a0a0_0001;
  localparam logic [47:0] TB = 48'h0000_b0b0_0002;
  localparam logic [47:0] TC = 48'h0000_c0c0_0003;
  localparam logic [47:0] TT = 48'h0001_0000_0077;
  logic        sys_clk;
  logic        sys_rst;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        probeClk;
  logic [95:0] probeData;
  logic        syncOut;
  logic        brkReq;
  logic [31:0] d;
  int          bad_count;
  int          compares;
  int          syncCnt;
  int          brkCnt;

  ltc_capture dut (
    .sys_clk  (sys_clk),   .sys_rst  (sys_rst),
    .regAddr  (regAddr),   .regWrData(regWrData),
    .regWr    (regWr),     .regRd    (regRd),
    .regRdData(regRdData), .probeClk (probeClk),
    .probeData(probeData), .syncOut  (syncOut),
    .brkReq   (brkReq)
  );
  ltc_probe_model probe (
    .sys_clk  (sys_clk), .probeClk (probeClk), .probeData(probeData)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (syncOut === 1'b1) syncCnt++;
    if (brkReq === 1'b1) brkCnt++;
  end

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask

  task automatic rdix(input logic [7:0] i, input logic [7:0] a,
                      output logic [31:0] v);
    wr(ltc_pkg::REG_RDIDX, {24'h0, i});
    rd(a, v);
  endtask

  function automatic logic [95:0] pw(input logic [15:0] x);
    return {80'h0, x};
  endfunction

  function automatic logic [31:0] cw(input logic [1:0] m, input logic x,
                                     input logic e, input logic [2:0] dp);
    return {13'h0, dp, 10'h0, e, x, m, 2'b01};
  endfunction

  task automatic trig(input int k, input logic [47:0] v, input logic [47:0] m,
                      input logic [2:0] lv, input logic brk);
    logic [7:0] b;
    b = 8'h40 + 8'(k * 16);
    wr(b, v[31:0]);
    wr(b + 8'h4, {7'h0, brk, 5'h0, lv, v[47:32]});
    wr(b + 8'h8, m[31:0]);
    wr(b + 8'hc, {16'h0, m[47:32]});
  endtask

  task automatic clr_trig();
    for (int k = 0; k < 8; k++) trig(k, M, M, 3'h7, 1'b0);
  endtask

  task automatic wait_done();
    for (int n = 0; n < 10; n++) begin
      rd(ltc_pkg::REG_STATUS, d);
      if (d[ltc_pkg::STS_DONE] === 1'b1) return;
    end
    bad_count++;
    $display("MISMATCH done expected 1 seen %h", d);
    end_of_test();
  endtask

  task automatic t_reset();
    rd(ltc_pkg::REG_STATUS, d);
    chk("status", 32'h0, d & 32'h7);
    rd(ltc_pkg::REG_RANGE, d);
    chk("range", 32'hffff_0000, d);
    wr(8'hfc, 32'h1234_5678);
    rd(8'hfc, d);
    chk("unmapped", 32'h0, d);
    rd(8'h40, d);
    chk("trigger read", 32'h0, d);
  endtask

  task automatic t_start();
    clr_trig();
    trig(0, TA, M, 3'h0, 1'b1);
    trig(1, TB, M, 3'h1, 1'b0);
    trig(2, TC, M, 3'h1, 1'b0);
    syncCnt = 0;
    brkCnt  = 0;
    wr(ltc_pkg::REG_CTRL, cw(ltc_pkg::MODE_START, 1'b0, 1'b1, 3'h1));
    probe.send(pw(16'h11));
    probe.send({48'h0, TA});
    rd(ltc_pkg::REG_STATUS, d);
    chk("level", 32'h1, {29'h0, d[10:8]});
    probe.send(pw(16'h12));
    chk("early sync", 32'h0, 32'(syncCnt));
    probe.send({48'h0000_1234_cafe, TC});
    chk("sync", 32'h1, 32'(syncCnt));
    for (int i = 1; i < 4; i++) probe.send(pw(16'h20 + 16'(i)));
    rdix(8'h0, ltc_pkg::REG_RDA0, d);
    chk("busy read", 32'h0, d);
    wr(ltc_pkg::REG_CTRL, 32'h2);
    rd(ltc_pkg::REG_STATUS, d);
    chk("fill", 32'h4, {24'h0, d[23:16]});
    rdix(8'h0, ltc_pkg::REG_RDA0, d);
    chk("a0", TC[31:0], d);
    rdix(8'h0, ltc_pkg::REG_RDA1, d);
    chk("a1", {16'h0, TC[47:32]}, d);
    rdix(8'h0, ltc_pkg::REG_RDB0, d);
    chk("b0", 32'h1234_cafe, d);
    rdix(8'h0, ltc_pkg::REG_RDTAG, d);
    chk("tag0", 32'h3, d);
    rdix(8'h3, ltc_pkg::REG_RDTAG, d);
    chk("tag3", 32'h6, d);
    rdix(8'h3, ltc_pkg::REG_RDA0, d);
    chk("a0 last", 32'h23, d);
    chk("brk", 32'h1, 32'(brkCnt));
  endtask

  task automatic t_end();
    clr_trig();
    trig(0, TT, M, 3'h0, 1'b0);
    wr(ltc_pkg::REG_CTRL, cw(ltc_pkg::MODE_END, 1'b0, 1'b0, 3'h0));
    for (int i = 0; i < 257; i++) probe.send(pw(16'(i)));
    probe.send({48'h0, TT});
    wait_done();
    chk("end fill", 32'hff, {24'h0, d[23:16]});
    rdix(8'h0, ltc_pkg::REG_RDA0, d);
    chk("end oldest", 32'h3, d);
    rdix(8'hfe, ltc_pkg::REG_RDA0, d);
    chk("end trigger", TT[31:0], d);
  endtask

  task automatic t_pre();
    clr_trig();
    trig(0, TT, M, 3'h0, 1'b0);
    wr(ltc_pkg::REG_PRE, 32'h2);
    wr(ltc_pkg::REG_CTRL, cw(ltc_pkg::MODE_PRE, 1'b0, 1'b0, 3'h0));
    for (int i = 1; i < 6; i++) probe.send(pw(16'(i)));
    probe.send({48'h0, TT});
    for (int j = 0; j < 252; j++) probe.send(pw(16'h100 + 16'(j)));
    wait_done();
    probe.send(pw(16'h55));
    rd(ltc_pkg::REG_STATUS, d);
    chk("pre fill", 32'hff, {24'h0, d[23:16]});
    rdix(8'h0, ltc_pkg::REG_RDA0, d);
    chk("pre 0", 32'h4, d);
    rdix(8'h1, ltc_pkg::REG_RDA0, d);
    chk("pre 1", 32'h5, d);
    rdix(8'h2, ltc_pkg::REG_RDA0, d);
    chk("pre trig", TT[31:0], d);
    rdix(8'hfe, ltc_pkg::REG_RDA0, d);
    chk("pre last", 32'h1fb, d);
  endtask

  task automatic t_split();
    clr_trig();
    trig(0, 48'h0, 48'h0, 3'h0, 1'b0);
    // eight tag bits replace the top byte of segment A
    wr(ltc_pkg::REG_CTRL,
       cw(ltc_pkg::MODE_START, 1'b0, 1'b0, 3'h0) | 32'h0000_0800);
    probe.send({48'h0, 48'hff00_0000_1234});
    probe.send({48'h0, 48'hff00_0000_1234});
    wr(ltc_pkg::REG_CTRL, 32'h2);
    rdix(8'h0, ltc_pkg::REG_RDA1, d);
    chk("split tag0", 32'h0, d);
    rdix(8'h1, ltc_pkg::REG_RDA1, d);
    chk("split a1", 32'h0000_0100, d);
    rdix(8'h1, ltc_pkg::REG_RDA0, d);
    chk("split a0", 32'h0000_1234, d);
  endtask

  task automatic t_range();
    clr_trig();
    trig(0, 48'h0, 48'h0, 3'h0, 1'b0);
    wr(ltc_pkg::REG_RANGE, 32'h0020_0010);
    for (int x = 0; x < 2; x++) begin
      wr(ltc_pkg::REG_CTRL, cw(ltc_pkg::MODE_START, x[0], 1'b0, 3'h0));
      probe.send(pw(16'h05));
      probe.send(pw(16'h15));
      probe.send(pw(16'h30));
      wr(ltc_pkg::REG_CTRL, 32'h2);
      rd(ltc_pkg::REG_STATUS, d);
      chk("rng fill", x ? 32'h2 : 32'h1, {24'h0, d[23:16]});
      rdix(8'h0, ltc_pkg::REG_RDA0, d);
      chk("rng word", x ? 32'h05 : 32'h15, d);
    end
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    $display("MISMATCH run length expected end seen limit");
    end_of_test();
  end

  initial begin
    sys_rst   = 1'b1;
    regAddr   = '0;
    regWrData = '0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    bad_count = 0;
    compares  = 0;
    syncCnt   = 0;
    brkCnt    = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_start();
    t_end();
    t_pre();
    t_split();
    t_range();
    end_of_test();
  end
endmodule
